// ===== lasp_pkg.sv
// Package with pin timing constants and types for the latched-address SRAM host
package lasp_pkg;
	localparam int LASP_CLK_NS = 10;
	localparam int LASP_AW = 11;
	localparam int LASP_DW = 8;
	// Grade-dependent minimum and maximum times in ns (standard grade defaults)
	localparam int LASP_T_ACC_NS = 200;   // chip enable to data valid, max
	localparam int LASP_T_OE_NS = 80;     // output enable to data valid, max
	localparam int LASP_T_CEL_NS = 200;   // chip enable low width, min
	localparam int LASP_T_CEH_NS = 80;    // chip enable high width, min
	localparam int LASP_T_CYC_NS = 280;   // falling edge spacing, min
	localparam int LASP_T_WRL_NS = 200;   // write strobe low width, min
	localparam int LASP_T_AH_NS = 50;     // address hold after fall, min
	localparam int LASP_T_DH_NS = 10;     // data hold after write end, min
	// Derived cycle counts, rounded up for minimum times
	localparam int LASP_C_ACC = (LASP_T_ACC_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_CEL = (LASP_T_CEL_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_CEH = (LASP_T_CEH_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_CYC = (LASP_T_CYC_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_WRL = (LASP_T_WRL_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_AH = (LASP_T_AH_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	localparam int LASP_C_DH = (LASP_T_DH_NS + LASP_CLK_NS - 1) / LASP_CLK_NS;
	// Low phase lasts long enough for access plus one sample cycle
	localparam int LASP_C_LOW = (LASP_C_CEL > LASP_C_ACC + 1) ?
		LASP_C_CEL : LASP_C_ACC + 1;
	localparam int LASP_C_HIGH = (LASP_C_CEH > LASP_C_CYC - LASP_C_LOW) ?
		LASP_C_CEH : LASP_C_CYC - LASP_C_LOW;
	localparam int LASP_CW = 6;
	localparam logic [LASP_CW-1:0] LASP_CNT_ZERO = 6'h00;
	localparam logic [LASP_CW-1:0] LASP_CNT_ONE = 6'h01;
	localparam logic [LASP_AW-1:0] LASP_ADDR_RST = 11'h000;
	localparam logic [LASP_DW-1:0] LASP_DATA_RST = 8'h00;
	typedef enum logic [3:0] {
		LASP_IDLE = 4'b0001,
		LASP_LOW = 4'b0010,
		LASP_HOLD = 4'b0100,
		LASP_HIGH = 4'b1000
	} lasp_state_t;
endpackage

// ===== lasp_timer_if.sv
// Interface carrying the phase timer load and done signals
`timescale 1ns/10ps
interface lasp_timer_if;
	logic load;
	logic [lasp_pkg::LASP_CW-1:0] count;
	logic done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

// ===== lasp_timer.sv
// Down counter that times each phase of a bus cycle
`timescale 1ns/10ps
module lasp_timer
	import lasp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	lasp_timer_if.tmr t
);
	logic [LASP_CW-1:0] cnt_q;
	// Load a phase length, then count down to zero and hold there
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= LASP_CNT_ZERO;
		end else if (t.load) begin
			cnt_q <= t.count;
		end else if (cnt_q != LASP_CNT_ZERO) begin
			cnt_q <= cnt_q - LASP_CNT_ONE;
		end
	end
	// Done in the last cycle of the phase; it must not look at load,
	// since the controller raises load from done in the same cycle
	assign t.done = (cnt_q == LASP_CNT_ONE);
endmodule // lasp_timer

// ===== lasp_host.sv
// Host controller that runs read and write cycles on a latched-address SRAM
`timescale 1ns/10ps
// Function
// - Host keeps write strobe high throughout a read.
// - Host holds chip enable high for minimum time between cycles.
// - Host may hold output enable high through a write.
// - Host meets write data setup and hold regardless of output enable.
// - Host avoids lowering chip and output enable before write strobe.
// - If chip enable rises first, data timing references that edge.
// - Back-to-back writes may keep write strobe low; ends on enable rise.
// - Host keeps chip enable low pulse at least minimum width.
// - Host spaces chip enable falling edges by minimum cycle time.
// - Host keeps write strobe low pulse at least minimum width.
module lasp_host
	import lasp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [LASP_AW-1:0] i_req_addr,
	input wire logic [LASP_DW-1:0] i_req_wdata,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [LASP_DW-1:0] o_rsp_rdata,
	output logic [LASP_AW-1:0] o_word_select,
	output logic o_chip_en_n,
	output logic o_write_en_n,
	output logic o_out_en_n,
	input wire logic [LASP_DW-1:0] i_shared_bus,
	output logic [LASP_DW-1:0] o_shared_bus,
	output logic o_shared_bus_oe
);
	lasp_state_t state_q, state_d;
	logic wr_q;
	logic [LASP_AW-1:0] addr_q;
	logic [LASP_DW-1:0] wdata_q;
	logic [LASP_DW-1:0] rdata_q;
	logic rsp_q;
	logic [LASP_DW-1:0] bus_s1_q, bus_s2_q;
	lasp_timer_if tif ();

	lasp_timer u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.t(tif)
	);

	// Cycle plan in clocks from the edge that takes a request:
	// that edge lowers chip enable together with the write strobe or
	// the output enable and shows the captured address and data;
	// the low phase covers the minimum low width and the access time;
	// all strobes rise together, so a write always ends on the chip
	// enable edge and data timing refers to it;
	// the host keeps driving write data for one hold clock;
	// chip enable then stays high long enough for both the high time
	// and the falling-edge spacing before ready returns.
	// Read data are the synchronised bus level of the clock before
	// chip enable rises.

	// Decoded conditions
	wire idle_w = (state_q == LASP_IDLE);
	wire take_w = idle_w && i_req_valid;
	wire low_done_w = (state_q == LASP_LOW) && tif.done;
	wire hold_done_w = (state_q == LASP_HOLD) && tif.done;
	wire high_done_w = (state_q == LASP_HIGH) && tif.done;
	wire in_cycle_w = (state_q == LASP_LOW);
	wire rd_take_w = hold_done_w && !wr_q;
	assign o_req_ready = idle_w;

	// Strobe and drive levels for the next clock
	wire open_w = take_w || (in_cycle_w && !low_done_w);
	wire wr_open_w = (take_w && i_req_write) ||
		(in_cycle_w && !low_done_w && wr_q);
	wire rd_open_w = (take_w && !i_req_write) ||
		(in_cycle_w && !low_done_w && !wr_q);
	wire tail_w = (state_q == LASP_HOLD) && !hold_done_w;
	wire drive_w = (take_w && i_req_write) ||
		((in_cycle_w || tail_w) && wr_q);

	// Phase lengths in clocks, cut to the timer width
	wire [LASP_CW-1:0] low_len_w = LASP_CW'(LASP_C_LOW);
	wire [LASP_CW-1:0] hold_len_w = LASP_CW'(LASP_C_DH);
	wire [LASP_CW-1:0] high_len_w = LASP_CW'(LASP_C_HIGH);

	// Next state and phase loading
	always_comb begin
		state_d = state_q;
		tif.load = 1'b0;
		tif.count = LASP_CNT_ZERO;
		unique case (state_q)
			LASP_IDLE: begin
				if (i_req_valid) begin
					state_d = LASP_LOW;
					tif.load = 1'b1;
					tif.count = low_len_w;
				end
			end
			LASP_LOW: begin
				if (tif.done) begin
					state_d = LASP_HOLD;
					tif.load = 1'b1;
					tif.count = hold_len_w;
				end
			end
			LASP_HOLD: begin
				if (tif.done) begin
					state_d = LASP_HIGH;
					tif.load = 1'b1;
					tif.count = high_len_w;
				end
			end
			LASP_HIGH: begin
				if (high_done_w) begin
					state_d = LASP_IDLE;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= LASP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Capture request; address stays put through the whole cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_q <= 1'b0;
			addr_q <= LASP_ADDR_RST;
			wdata_q <= LASP_DATA_RST;
		end else if (take_w) begin
			wr_q <= i_req_write;
			addr_q <= i_req_addr;
			wdata_q <= i_req_wdata;
		end
	end

	// Two-flop synchroniser on the data bus pins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bus_s1_q <= LASP_DATA_RST;
			bus_s2_q <= LASP_DATA_RST;
		end else begin
			bus_s1_q <= i_shared_bus;
			bus_s2_q <= bus_s1_q;
		end
	end

	// Response pulse in the clock after a read's hold phase
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rsp_q <= 1'b0;
		end else begin
			rsp_q <= rd_take_w;
		end
	end

	// Read data loaded at the end of the hold phase from the bus level synchronised after access time
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= LASP_DATA_RST;
		end else if (rd_take_w) begin
			rdata_q <= bus_s2_q;
		end
	end

	// Chip enable low through the low phase only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_chip_en_n <= 1'b1;
		end else begin
			o_chip_en_n <= !open_w;
		end
	end

	// Write strobe falls and rises with chip enable, ending the write there
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_write_en_n <= 1'b1;
		end else begin
			o_write_en_n <= !wr_open_w;
		end
	end

	// Output enable only in a read, so a write never meets a driven bus
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_out_en_n <= 1'b1;
		end else begin
			o_out_en_n <= !rd_open_w;
		end
	end

	// Host drives write data one clock past the strobes for data hold
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_shared_bus_oe <= 1'b0;
		end else begin
			o_shared_bus_oe <= drive_w;
		end
	end

	// Address and data pins come straight from the captured request
	assign o_word_select = addr_q;
	assign o_shared_bus = wdata_q;
	assign o_rsp_valid = rsp_q;
	assign o_rsp_rdata = rdata_q;
endmodule // lasp_host

// ===== lasp_sram_model.sv
// Behavioural model of the latched-address 2K x 8 static RAM
`timescale 1ns/10ps
module lasp_sram_model #(
	parameter int DLY = 190
) (
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [10:0] i_a,
	input wire logic [7:0] i_d,
	output logic [7:0] o_q,
	output logic o_drv
);
	logic [7:0] mem [2048];
	logic [10:0] lat_q = 11'h000;
	logic ok = 1'b0;
	logic wr = 1'b0;
	// Address taken just after the opening edge, well inside its hold
	// time, so the host's address update in the same step is not raced
	always @(negedge i_ce_n) begin
		ok = 1'b0;
		ok <= #(DLY) 1'b1;
		#1 lat_q = i_a;
	end
	// Write armed while both strobes low, stored at the first rise
	always @(i_ce_n or i_we_n) begin
		if (!i_ce_n && !i_we_n)
			wr = 1'b1;
		else if (wr) begin
			mem[lat_q] = i_d;
			wr = 1'b0;
		end
	end
	// Drives only while selected in read mode with outputs enabled
	assign o_drv = !i_ce_n && !i_oe_n && i_we_n;
	assign o_q = ok ? mem[lat_q] : ~mem[lat_q];
endmodule // lasp_sram_model

// ===== lasp_host_checker.sv
// Pin timing checker for the SRAM host
`timescale 1ns/10ps
module lasp_host_checker
	import lasp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic o_req_ready,
	input wire logic o_rsp_valid,
	input wire logic [LASP_AW-1:0] o_word_select,
	input wire logic o_chip_en_n,
	input wire logic o_write_en_n,
	input wire logic o_out_en_n,
	input wire logic [LASP_DW-1:0] o_shared_bus,
	input wire logic o_shared_bus_oe
);
	int lo_q = 0;
	int hi_q = 0;
	int sp_q = LASP_C_CYC; // No earlier cycle to space from
	int wl_q = 0;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Width counters of the chip enable and write strobe phases, and falling-edge spacing
	always_ff @(posedge i_clk) begin
		lo_q <= o_chip_en_n ? 0 : lo_q + 1;
		hi_q <= o_chip_en_n ? hi_q + 1 : 0;
		sp_q <= $fell(o_chip_en_n) ? 1 : sp_q + 1;
		wl_q <= o_write_en_n ? 0 : wl_q + 1;
	end
	sequence rd_end_s;
		$rose(o_chip_en_n) && $past(o_out_en_n) == 1'b0;
	endsequence
	sequence wr_end_s;
		$rose(o_write_en_n);
	endsequence
	ce_low_a: assert property ($rose(o_chip_en_n) |-> lo_q == LASP_C_LOW)
		else $error("chip enable low width wrong");
	ce_high_a: assert property ($fell(o_chip_en_n) |-> hi_q >= LASP_C_CEH)
		else $error("chip enable high time short");
	ce_spacing_a: assert property ($fell(o_chip_en_n) |-> sp_q >= LASP_C_CYC)
		else $error("cycle spacing short");
	we_width_a: assert property (wr_end_s |-> wl_q >= LASP_C_WRL)
		else $error("write strobe width short");
	read_mode_a: assert property (!o_out_en_n |-> o_write_en_n && !o_shared_bus_oe)
		else $error("write strobe or drive during read");
	addr_held_a: assert property (!o_chip_en_n && !$fell(o_chip_en_n) |-> $stable(o_word_select))
		else $error("address moved in cycle");
	wr_hold_a: assert property (wr_end_s |-> o_shared_bus_oe && $stable(o_shared_bus))
		else $error("write data not held");
	wr_drive_a: assert property (!o_write_en_n |-> o_shared_bus_oe && o_out_en_n)
		else $error("write without bus drive");
	rsp_time_a: assert property (rd_end_s |-> ##1 o_rsp_valid)
		else $error("read response late");
	ready_idle_a: assert property (o_req_ready |-> o_chip_en_n && o_write_en_n)
		else $error("ready while cycle open");
endmodule // lasp_host_checker
bind lasp_host lasp_host_checker lasp_host_checker_inst (.*);

// ===== latched_address_sram_port_tb.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/10ps
module latched_address_sram_port_tb
	import lasp_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_req_valid = 1'b0;
	logic i_req_write = 1'b0;
	logic [LASP_AW-1:0] i_req_addr = 11'h000;
	logic [LASP_AW-1:0] o_word_select;
	logic [LASP_DW-1:0] i_req_wdata = 8'h00;
	logic [LASP_DW-1:0] last = 8'h00;
	logic [LASP_DW-1:0] bus, m_q, o_rsp_rdata, o_shared_bus;
	logic o_req_ready, o_rsp_valid, o_chip_en_n, o_write_en_n, o_out_en_n;
	logic o_shared_bus_oe, m_drv;
	int n_mismatch = 0;
	int n_compared = 0;
	localparam logic [10:0] ADR [4] = '{11'h000, 11'h7ff, 11'h2aa, 11'h2aa};
	localparam logic [7:0] DAT [4] = '{8'ha5, 8'h5a, 8'h0f, 8'hf0};
	localparam int WR_CYC = LASP_C_LOW + LASP_C_DH + LASP_C_HIGH + 1;
	always #5 i_clk = ~i_clk;
	// Bus level: host, then memory, else a value changing every cycle
	assign bus = o_shared_bus_oe ? o_shared_bus : m_drv ? m_q : ~last;
	always @(posedge i_clk) last <= bus;
	lasp_host lasp_host_inst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_req_valid(i_req_valid),
		.i_req_write(i_req_write),
		.i_req_addr(i_req_addr),
		.i_req_wdata(i_req_wdata),
		.o_req_ready(o_req_ready),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_rdata(o_rsp_rdata),
		.o_word_select(o_word_select),
		.o_chip_en_n(o_chip_en_n),
		.o_write_en_n(o_write_en_n),
		.o_out_en_n(o_out_en_n),
		.i_shared_bus(bus),
		.o_shared_bus(o_shared_bus),
		.o_shared_bus_oe(o_shared_bus_oe)
	);
	lasp_sram_model lasp_sram_model_inst (.i_ce_n(o_chip_en_n),
		.i_we_n(o_write_en_n), .i_oe_n(o_out_en_n), .i_a(o_word_select),
		.i_d(bus), .o_q(m_q), .o_drv(m_drv));
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One request; held while refused, then waits for its completion
	task automatic op(logic w, logic [10:0] a, logic [7:0] d,
		output logic [7:0] q, output int n);
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req_write <= w;
		i_req_addr <= a;
		i_req_wdata <= d;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (o_req_ready !== 1'b1 && n < 99);
		chk("ready", 16'h0001, {15'h0000, o_req_ready});
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while ((w ? o_req_ready : o_rsp_valid) !== 1'b1 && n < 99);
		chk("done", 16'h0001, {15'h0000, (w ? o_req_ready : o_rsp_valid)});
		q = o_rsp_rdata;
	endtask
	// Back-to-back writes with an overwrite, then read-back and latency
	task automatic t_rw;
		logic [7:0] q;
		int n;
		for (int i = 0; i < 4; i++) begin
			op(1'b1, ADR[i], DAT[i], q, n);
			chk("wr_cycle", 16'(WR_CYC), 16'(n));
		end
		for (int i = 0; i < 4; i++) begin
			if (i == 2) continue;
			op(1'b0, ADR[i], 8'h00, q, n);
			chk("rdata", {8'h00, DAT[i]}, {8'h00, q});
			chk("latency", 16'(LASP_C_LOW + LASP_C_DH + 1), 16'(n));
		end
	endtask
	// Reset in mid-write releases the strobes and spares other words
	task automatic t_mid_reset;
		logic [7:0] q;
		int n;
		@(posedge i_clk);
		i_req_write <= 1'b1;
		i_req_addr <= 11'h005;
		i_req_valid <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_req_valid <= 1'b0;
		i_rst <= 1'b1;
		repeat (30) @(posedge i_clk);
		chk("pins", 16'h000e, {12'h000, o_chip_en_n, o_write_en_n,
			o_out_en_n, o_shared_bus_oe});
		i_rst <= 1'b0;
		op(1'b0, ADR[1], 8'h00, q, n);
		chk("rdata", {8'h00, DAT[1]}, {8'h00, q});
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		t_rw();
		t_mid_reset();
		end_sim();
	end
	// Watchdog well beyond the nine cycles of about 30 clocks each
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule // latched_address_sram_port_tb
